// *** rtl/abu_breakpoint.v ***
// address breakpoint unit: registers, break request sequencing, side controls
// assumes the cpu core drives address, boundary and rti strobes on clk
`include "abu_map.vh"

module abu_breakpoint (
    // clock and reset
    input  wire        clk,
    input  wire        resetn,
    // register port
    input  wire [15:0] reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    // cpu core
    input  wire [15:0] cpu_addr,
    input  wire        cpu_addr_valid,
    input  wire        instr_last_cycle,
    input  wire        rti_in_break,
    input  wire        wait_mode,
    input  wire        stop_mode,
    input  wire        monitor_mode,
    output wire        break_req,
    output wire        break_in_progress,
    output wire [15:0] break_vector,
    output wire        stop_exit,
    // system controls
    input  wire        test_voltage_pin,
    output wire        timers_stop,
    output wire        watchdog_disable,
    output wire        flag_clear_allowed
);

    // ****************************************
    // vectors used by the cpu on a break
    // ****************************************
    localparam [15:0] VEC_USER    = 16'hfffc;
    localparam [15:0] VEC_MONITOR = 16'hfefc;

    // ****************************************
    // state
    // ****************************************
    reg        match_enable_reg;
    reg        active_flag_reg;
    reg        wait_exit_flag_reg;
    reg        clear_en_reg;
    reg [7:0]  addr_high_reg;
    reg [7:0]  addr_low_reg;
    reg [1:0]  state_reg;
    reg [1:0]  state_next;
    reg        tst_meta_reg;
    reg        tst_sync_reg;
    wire       addr_hit;
    wire       soft_break;
    wire       break_start;

    // register offset decode, used by read and write paths
    function is_off;
        input [15:0] a;
        input [15:0] off;
        begin
            is_off = (a == off);
        end
    endfunction

    // ****************************************
    // comparator
    // ****************************************
    abu_comparator u_cmp (
        .cpu_addr     (cpu_addr),
        .break_addr   ({addr_high_reg, addr_low_reg}),
        .match_enable (match_enable_reg & cpu_addr_valid),
        .addr_hit     (addr_hit)
    );

    // software writing one to the active bit asks for a break
    assign soft_break = reg_wr && is_off(reg_addr, `ABU_OFF_STATUS_CTRL)
                        && reg_wdata[`ABU_BIT_ACTIVE];

    // ****************************************
    // test-voltage synchroniser, pin is asynchronous
    // ****************************************
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tst_meta_reg <= 1'b0;
            tst_sync_reg <= 1'b0;
        end else begin
            tst_meta_reg <= test_voltage_pin;
            tst_sync_reg <= tst_meta_reg;
        end
    end

    // ****************************************
    // break sequencer
    // ****************************************
    // a break starts at an instruction boundary; a hit on the last cycle
    // goes straight in, so no extra instruction slips through
    assign break_start = (state_reg != `ABU_ST_BREAK) && (state_next == `ABU_ST_BREAK);

    always @* begin
        state_next = state_reg;
        case (state_reg)
            `ABU_ST_IDLE: begin
                if (addr_hit || soft_break) begin
                    if (instr_last_cycle) begin
                        state_next = `ABU_ST_BREAK;
                    end else begin
                        state_next = `ABU_ST_PEND;
                    end
                end
            end
            `ABU_ST_PEND: begin
                if (instr_last_cycle) begin
                    state_next = `ABU_ST_BREAK;
                end
            end
            `ABU_ST_BREAK: begin
                if (rti_in_break) begin
                    state_next = `ABU_ST_IDLE;
                end
            end
            default: state_next = `ABU_ST_IDLE;
        endcase
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= `ABU_ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // request held until the cpu is in the break, so it is never missed
    assign break_req         = (state_reg == `ABU_ST_PEND) || ((state_reg == `ABU_ST_IDLE)
                               && (addr_hit || soft_break));
    assign break_in_progress = (state_reg == `ABU_ST_BREAK);
    assign break_vector      = monitor_mode ? VEC_MONITOR : VEC_USER;
    // a pending break wakes the core from stop
    assign stop_exit         = stop_mode && break_req;

    // ****************************************
    // side controls during the break state
    // ****************************************
    assign timers_stop        = break_in_progress;
    assign watchdog_disable   = break_in_progress && tst_sync_reg;
    assign flag_clear_allowed = !break_in_progress || clear_en_reg;

    // ****************************************
    // register writes and flag updates
    // ****************************************
    // hardware sets win over software clears in the same cycle
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            match_enable_reg   <= 1'b0;
            active_flag_reg    <= 1'b0;
            wait_exit_flag_reg <= 1'b0;
            clear_en_reg       <= 1'b0;
            addr_high_reg      <= `ABU_RST_BYTE;
            addr_low_reg       <= `ABU_RST_BYTE;
        end else begin
            if (reg_wr && is_off(reg_addr, `ABU_OFF_ADDR_HIGH)) begin
                addr_high_reg <= reg_wdata;
            end
            if (reg_wr && is_off(reg_addr, `ABU_OFF_ADDR_LOW)) begin
                addr_low_reg <= reg_wdata;
            end
            if (reg_wr && is_off(reg_addr, `ABU_OFF_FLAG_CLEAR)) begin
                clear_en_reg <= reg_wdata[`ABU_BIT_CLEAR_EN];
            end
            if (reg_wr && is_off(reg_addr, `ABU_OFF_STATUS_CTRL)) begin
                match_enable_reg <= reg_wdata[`ABU_BIT_ENABLE];
            end
            // match or software one sets; writing zero clears
            if (addr_hit || soft_break) begin
                active_flag_reg <= 1'b1;
            end else if (reg_wr && is_off(reg_addr, `ABU_OFF_STATUS_CTRL)
                         && !reg_wdata[`ABU_BIT_ACTIVE]) begin
                active_flag_reg <= 1'b0;
            end
            // break entered from wait or stop marks the exit
            if (break_start && (wait_mode || stop_mode)) begin
                wait_exit_flag_reg <= 1'b1;
            end else if (reg_wr && is_off(reg_addr, `ABU_OFF_WAIT_STATUS)
                         && !reg_wdata[`ABU_BIT_WAIT_EXIT]) begin
                wait_exit_flag_reg <= 1'b0;
            end
        end
    end

    // ****************************************
    // read path, data one cycle after strobe
    // ****************************************
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= `ABU_ZERO_BYTE;
        end else if (reg_rd) begin
            reg_rdata <= `ABU_ZERO_BYTE;
            if (is_off(reg_addr, `ABU_OFF_WAIT_STATUS)) begin
                reg_rdata[`ABU_BIT_FIXED_ONE] <= 1'b1;
                reg_rdata[`ABU_BIT_WAIT_EXIT] <= wait_exit_flag_reg;
            end
            if (is_off(reg_addr, `ABU_OFF_FLAG_CLEAR)) begin
                reg_rdata[`ABU_BIT_CLEAR_EN] <= clear_en_reg;
            end
            if (is_off(reg_addr, `ABU_OFF_ADDR_HIGH)) begin
                reg_rdata <= addr_high_reg;
            end
            if (is_off(reg_addr, `ABU_OFF_ADDR_LOW)) begin
                reg_rdata <= addr_low_reg;
            end
            if (is_off(reg_addr, `ABU_OFF_STATUS_CTRL)) begin
                reg_rdata[`ABU_BIT_ENABLE] <= match_enable_reg;
                reg_rdata[`ABU_BIT_ACTIVE] <= active_flag_reg;
            end
        end
    end

endmodule // abu_breakpoint

// *** common/abu_map.vh ***
// address breakpoint unit: register offsets, field positions and reset values
// assumes a 16-bit cpu address space and an 8-bit register port
//
// Overview of operation
// - request a break when the cpu address equals the 16-bit break address.
// - cpu takes the break as a software interrupt through user or monitor vector.
// - writing one to the active flag causes a break like a match.
// - return from interrupt in the break routine ends the break state.
// - break starts after current instruction; match on last cycle starts at once.
// - both timer counters stay stopped while the break is in effect.
// - watchdog disabled during break only with test voltage on reset pin.
// - flags elsewhere clearable during break only when clear enable bit is one.
// - matching works in wait mode; a break leaving wait sets the wait-exit flag.
// - a break ends stop mode and sets the wait-exit flag.
// - wait-exit flag clears only by writing zero; writing one leaves it.
// - control register: enable bit 7, active bit 6, rest read zero, reset zero.
// - status register: wait-exit bit 1, bit 4 reads one, others zero.
// - address-match breaks only while enable is one; reset clears enable.
// - match sets active flag; software clears it by writing zero.
`ifndef ABU_MAP_VH
`define ABU_MAP_VH

// ****************************************
// register offsets
// ****************************************
`define ABU_OFF_WAIT_STATUS   16'hfe00
`define ABU_OFF_FLAG_CLEAR    16'hfe03
`define ABU_OFF_ADDR_HIGH     16'hfe09
`define ABU_OFF_ADDR_LOW      16'hfe0a
`define ABU_OFF_STATUS_CTRL   16'hfe0b

// ****************************************
// field positions and reset values
// ****************************************
`define ABU_BIT_ENABLE        7
`define ABU_BIT_ACTIVE        6
`define ABU_BIT_CLEAR_EN      7
`define ABU_BIT_WAIT_EXIT     1
`define ABU_BIT_FIXED_ONE     4
`define ABU_RST_BYTE          8'h00
`define ABU_RST_ADDR          16'h0000
`define ABU_ZERO_BYTE         8'h00

// ****************************************
// break sequencer states
// ****************************************
`define ABU_ST_IDLE           2'h0
`define ABU_ST_PEND           2'h1
`define ABU_ST_BREAK          2'h2

`endif

// *** rtl/abu_comparator.v ***
// address breakpoint unit: registered-free 16-bit address comparator
// assumes address and break value are on the same clock as the caller
`include "abu_map.vh"

module abu_comparator (
    // compare operands
    input  wire [15:0] cpu_addr,
    input  wire [15:0] break_addr,
    input  wire        match_enable,
    // result
    output wire        addr_hit
);

    // ****************************************
    // compare
    // ****************************************
    // gated by the enable so a stale address cannot break
    assign addr_hit = match_enable && (cpu_addr == break_addr);

endmodule // abu_comparator

// *** sim/abu_sva.sv ***
// checker: port assertions for the breakpoint unit
// assumes it is bound to abu_breakpoint and sees only its ports
module abu_sva (
    // clock, reset and register port
    input logic        clk, resetn, reg_wr, reg_rd,
    input logic [15:0] reg_addr,
    input logic [7:0]  reg_wdata, reg_rdata,
    // cpu side and system controls
    input logic [15:0] cpu_addr,
    input logic        cpu_addr_valid, instr_last_cycle, rti_in_break, stop_mode,
    input logic        break_req, break_in_progress, stop_exit, timers_stop,
    input logic        flag_clear_allowed
);
    logic        en_q, bc_q;
    logic [15:0] ba_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // shadow of written control bits, the registers are out of sight here
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            {en_q, bc_q, ba_q} <= 18'h00000;
        end else if (reg_wr) begin
            if (reg_addr == 16'hfe0b) en_q <= reg_wdata[7];
            if (reg_addr == 16'hfe03) bc_q <= reg_wdata[7];
            if (reg_addr == 16'hfe09) ba_q[15:8] <= reg_wdata;
            if (reg_addr == 16'hfe0a) ba_q[7:0] <= reg_wdata;
        end
    end
    property p_match; en_q && cpu_addr_valid && cpu_addr == ba_q && !break_in_progress
        |-> break_req; endproperty
    a_match: assert property (p_match) else $error("hit without request");
    property p_end; break_in_progress && rti_in_break |=> !break_in_progress; endproperty
    a_end: assert property (p_end) else $error("break outlived rti");
    property p_start; break_req && $past(break_req) && instr_last_cycle
        && !break_in_progress |=> break_in_progress; endproperty
    a_start: assert property (p_start) else $error("no break at boundary");
    property p_hold; !break_req && !break_in_progress |=> !break_in_progress; endproperty
    a_hold: assert property (p_hold) else $error("break without cause");
    property p_tim; timers_stop == break_in_progress; endproperty
    a_tim: assert property (p_tim) else $error("timer stop wrong");
    property p_fca; flag_clear_allowed == (!break_in_progress || bc_q); endproperty
    a_fca: assert property (p_fca) else $error("flag clear wrong");
    property p_stop; stop_mode && break_req |-> stop_exit; endproperty
    a_stop: assert property (p_stop) else $error("stop not left");
    property p_sts; reg_rd && reg_addr == 16'hfe00 |=> (reg_rdata & 8'hfd) == 8'h10;
        endproperty
    a_sts: assert property (p_sts) else $error("status fixed bits wrong");
endmodule // abu_sva

bind abu_breakpoint abu_sva abu_sva_inst (.clk, .resetn, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .cpu_addr, .cpu_addr_valid, .instr_last_cycle, .rti_in_break,
    .stop_mode, .break_req, .break_in_progress, .stop_exit, .timers_stop,
    .flag_clear_allowed);

// *** sim/abu_cpu_model.sv ***
// partner: cpu stand-in, two-cycle instructions over a 64-byte loop
// assumes shared clk and resetn; rel from the bench allows the rti
module abu_cpu_model (
    input  logic        clk,
    input  logic        resetn,
    input  logic        in_brk,
    input  logic        rel,
    output logic [15:0] cpu_addr,
    output logic        addr_ok,
    output logic        last_cyc,
    output logic        return_from_interrupt
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] pc;
    // fetch stalls in break; rti waits for the bench so flags get cleared
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            {pc, last_cyc, return_from_interrupt} <= {16'h1200, 2'h0};
        end else begin
            if (!in_brk) pc <= {pc[15:6], pc[5:0] + 6'h01};
            if (!in_brk) last_cyc <= ~last_cyc;
            return_from_interrupt <= in_brk && rel && !return_from_interrupt;
        end
    end
    // stalled bus shows the inverted address, never a stale one
    assign cpu_addr = in_brk ? ~pc : pc;
    assign addr_ok = !in_brk;
endmodule // abu_cpu_model

// *** sim/tb.sv ***
// testbench: registers, match, soft, wait and stop breaks, self-checking
// assumes unit, cpu model and checker compiled before it
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 1'b0, resetn = 1'b0, we = 1'b0, re = 1'b0, rel = 1'b0;
    logic        wm = 1'b0, sm = 1'b0, mm = 1'b0, tvp = 1'b0;
    logic [15:0] ra = 16'h0000;
    logic [7:0]  wd = 8'h00;
    int          fail_count = 0, cmp_count = 0, cyc = 0;
    wire  [15:0] ca, bvec;
    wire  [7:0]  rdata;
    wire         cav, lc, return_from_interrupt, brq, bip, sx, ts, wdd, fca;
    abu_breakpoint abu_breakpoint_inst (.clk(clk), .resetn(resetn), .reg_addr(ra),
        .reg_wdata(wd), .reg_wr(we), .reg_rd(re), .reg_rdata(rdata), .cpu_addr(ca),
        .cpu_addr_valid(cav), .instr_last_cycle(lc), .rti_in_break(return_from_interrupt), .wait_mode(wm),
        .stop_mode(sm), .monitor_mode(mm), .break_req(brq), .break_in_progress(bip),
        .break_vector(bvec), .stop_exit(sx), .test_voltage_pin(tvp), .timers_stop(ts),
        .watchdog_disable(wdd), .flag_clear_allowed(fca));
    abu_cpu_model abu_cpu_model_inst (.clk(clk), .resetn(resetn), .in_brk(bip),
        .rel(rel), .cpu_addr(ca), .addr_ok(cav), .last_cyc(lc), .return_from_interrupt(return_from_interrupt));
    initial begin
        forever #12.5 clk = ~clk;
    end
    // hang guard, far above the hundred or so cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            fail_count++;
            end_sim;
        end
    end
    task chk(input logic [15:0] g, input logic [15:0] e);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task cb(input logic g, input logic e);
        chk({15'h0000, g}, {15'h0000, e});
    endtask
    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        ra <= a; wd <= d; we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask
    task rdc(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        ra <= a; re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1 chk({8'h00, rdata}, {8'h00, e});
    endtask
    // bounded wait for the break state to reach v
    task wt(input logic v);
        int n;
        n = 0;
        #1;
        while (bip !== v && n < 200) begin
            @(posedge clk);
            #1 n++;
        end
        cb(bip, v);
    endtask
    // end of the break routine: the model may now issue its rti
    task fin;
        @(posedge clk);
        rel <= 1'b1;
        wt(1'b0);
        @(posedge clk);
        rel <= 1'b0;
        cb(ts, 1'b0);
    endtask
    task t_reset;
        rdc(16'hfe00, 8'h10);
        rdc(16'hfe03, 8'h00);
        rdc(16'hfe09, 8'h00);
        rdc(16'hfe0a, 8'h00);
        rdc(16'hfe0b, 8'h00);
        $display("test reset done");
    endtask
    task t_regs;
        wr(16'hfe09, 8'ha5);
        wr(16'hfe0a, 8'h5a);
        wr(16'hfe0b, 8'hbf);
        wr(16'hfe03, 8'hff);
        wr(16'hfe00, 8'hff);
        wr(16'hfe01, 8'hff);
        rdc(16'hfe09, 8'ha5);
        rdc(16'hfe0a, 8'h5a);
        rdc(16'hfe0b, 8'h80);
        rdc(16'hfe03, 8'h80);
        rdc(16'hfe00, 8'h10);
        rdc(16'hfe01, 8'h00);
        $display("test regs done");
    endtask
    task t_match;
        @(posedge clk);
        tvp <= 1'b1;
        wr(16'hfe09, 8'h12);
        wr(16'hfe0a, 8'h34);
        wt(1'b1);
        cb(ts, 1'b1);
        cb(wdd, 1'b1);
        cb(fca, 1'b1);
        rdc(16'hfe0b, 8'hc0);
        wr(16'hfe0b, 8'h00);
        rdc(16'hfe0b, 8'h00);
        fin;
        $display("test match done");
    endtask
    task t_soft;
        @(posedge clk);
        wm <= 1'b1; mm <= 1'b1; tvp <= 1'b0;
        wr(16'hfe03, 8'h00);
        wr(16'hfe0b, 8'h40);
        wt(1'b1);
        chk(bvec, 16'hfefc);
        cb(wdd, 1'b0);
        cb(fca, 1'b0);
        rdc(16'hfe00, 8'h12);
        wr(16'hfe00, 8'h02);
        rdc(16'hfe00, 8'h12);
        wr(16'hfe00, 8'h00);
        rdc(16'hfe00, 8'h10);
        wr(16'hfe0b, 8'h00);
        fin;
        wm <= 1'b0; mm <= 1'b0;
        $display("test soft done");
    endtask
    task t_stop;
        @(posedge clk);
        sm <= 1'b1; ra <= 16'hfe0b; wd <= 8'h40; we <= 1'b1;
        #1 cb(sx, 1'b1);
        @(posedge clk);
        we <= 1'b0;
        wt(1'b1);
        chk(bvec, 16'hfffc);
        rdc(16'hfe00, 8'h12);
        wr(16'hfe00, 8'h00);
        wr(16'hfe0b, 8'h00);
        fin;
        sm <= 1'b0;
        $display("test stop done");
    endtask
    task end_sim;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        t_reset;
        t_regs;
        t_match;
        t_soft;
        t_stop;
        end_sim;
    end
endmodule // tb
